// ---- hdl/cab_defines.vh ----
// Purpose: shared constants of the add/and/branch execution block
// Assumes: 32-bit Avalon-MM register window, word aligned offsets
// Notes:   definitions only
`ifndef CAB_DEFINES_VH
`define CAB_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CAB_OFS_CTRL     6'h00
`define CAB_OFS_INSTR    6'h04
`define CAB_OFS_ACC      6'h08
`define CAB_OFS_STATUS   6'h0c
`define CAB_OFS_BANK_SEL 6'h10
`define CAB_OFS_PC       6'h14
`define CAB_OFS_IDX_BASE 6'h18
`define CAB_OFS_MADDR    6'h1c
`define CAB_OFS_MDATA    6'h20

// ----------------------------------------
// Status field positions and control bits
// ----------------------------------------
`define CAB_ST_C         0
`define CAB_ST_DIGIT     1
`define CAB_ST_Z         2
`define CAB_ST_OVF       3
`define CAB_ST_N         4
`define CAB_ST_BUSY      8
`define CAB_CTRL_EXT_SET 0

// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define CAB_OP_ADDC      6'h08
`define CAB_OP_ANDF      6'h05
`define CAB_OP_ANDL      8'h0b
`define CAB_OP_BRC       8'he2

// ----------------------------------------
// Addressing and reset values
// ----------------------------------------
`define CAB_ACC_SPLIT    8'h60
`define CAB_IDX_LIMIT    8'h5f
`define CAB_SFR_BANK     4'hf
`define CAB_PC_STEP      21'h000002
`define CAB_RST_ACC      8'h00
`define CAB_RST_STATUS   5'h00
`define CAB_RST_PC       21'h000000
`define CAB_RST_BANK_SEL 4'h0
`define CAB_QUARTERS     2'h3

`endif

// ---- hdl/cab_alu.v ----
// Purpose: arithmetic and logic unit of the execution block
// Assumes: purely combinational, results latched by the caller
// Notes:   zero and negative always computed, carry, digit and overflow only for add; caller chooses which to keep
`include "cab_defines.vh"

module cab_alu (
	input  wire       op_and,
	input  wire [7:0] opnd_a,
	input  wire [7:0] opnd_b,
	input  wire       carry_in,
	output reg  [7:0] result,
	output reg  [4:0] flags
);
	// ----------------------------------------
	// Sum pieces
	// ----------------------------------------
	wire [8:0] sum_full;   // Byte sum with carry out
	wire [4:0] sum_low;    // Nibble sum for digit carry

	assign sum_full = {1'b0, opnd_a} + {1'b0, opnd_b} + {8'h00, carry_in};
	assign sum_low  = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]}
		+ {4'h0, carry_in};

	// Result and flag selection
	always @* begin
		flags = 5'h00;
		if (op_and) begin
			result = opnd_a & opnd_b;
		end else begin
			result = sum_full[7:0];
			flags[`CAB_ST_C]  = sum_full[8];
			flags[`CAB_ST_DIGIT] = sum_low[4];
			// Overflow: like signs in, other sign out
			flags[`CAB_ST_OVF] = (opnd_a[7] == opnd_b[7]) &&
				(sum_full[7] != opnd_a[7]);
		end
		flags[`CAB_ST_N] = result[7];
		flags[`CAB_ST_Z] = (result == 8'h00);
	end
endmodule // cab_alu

// ---- hdl/cab_core.v ----
// Purpose: executes add-with-carry, AND and branch-on-carry
// Assumes: software loads an instruction word and it runs once
// Notes:   one instruction cycle is four core_clk quarters
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`include "cab_defines.vh"

module cab_core (
	input  wire        core_clk,
	input  wire        rst,
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	output reg         exec_busy
);
	// ----------------------------------------
	// Phase machine states
	// ----------------------------------------
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_Q1   = 3'h1;
	localparam [2:0] S_Q2   = 3'h2;
	localparam [2:0] S_Q3   = 3'h3;
	localparam [2:0] S_Q4   = 3'h4;
	localparam [2:0] S_NOP  = 3'h5;

	// Operation classes
	localparam [2:0] K_NONE = 3'h0;
	localparam [2:0] K_ADDC = 3'h1;
	localparam [2:0] K_ANDF = 3'h2;
	localparam [2:0] K_ANDL = 3'h3;
	localparam [2:0] K_BRC  = 3'h4;

	// ----------------------------------------
	// Architectural state
	// ----------------------------------------
	reg  [7:0]  mem [0:4095];   // Data memory, 16 banks of 256
	reg  [7:0]  acc;            // Accumulator
	reg  [4:0]  status;         // Negative, overflow, zero, digit, carry
	reg  [3:0]  bank_select_reg;
	reg  [20:0] pc;             // Program counter, even only
	reg  [11:0] idx_base;       // Base for indexed literal offset
	reg  [11:0] mem_addr;       // Software window into memory
	reg         ext_set_en;     // Extended instruction set enable
	reg  [15:0] instr;          // Word to execute
	reg  [2:0]  state;
	reg  [1:0]  quarter;        // Quarter count inside NOP cycle
	reg  [2:0]  kind;           // Decoded class, held from Q1
	reg  [11:0] eff_addr;       // Resolved file address
	reg  [7:0]  operand;        // Byte read in Q2
	reg  [7:0]  res;            // Result latched in Q3
	reg  [4:0]  res_flags;
	reg         take_branch;

	// Bus access strobes
	wire        bus_req;
	wire        wr_go;
	wire        rd_fire;
	assign bus_req = avs_read | avs_write;
	assign rd_fire = avs_read & avs_waitrequest;
	assign wr_go   = avs_write & ~avs_waitrequest;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Classify an instruction word by its opcode bits
	function [2:0] decode_kind;
		input [15:0] w;
		begin
			if (w[15:10] == `CAB_OP_ADDC)
				decode_kind = K_ADDC;
			else if (w[15:10] == `CAB_OP_ANDF)
				decode_kind = K_ANDF;
			else if (w[15:8] == `CAB_OP_ANDL)
				decode_kind = K_ANDL;
			else if (w[15:8] == `CAB_OP_BRC)
				decode_kind = K_BRC;
			else
				decode_kind = K_NONE;
		end
	endfunction

	// Merge write data into a word under byte enables
	function [31:0] be_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  be;
		integer      i;
		begin
			be_merge = old_v;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i])
					be_merge[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
	endfunction

	// ----------------------------------------
	// File address resolution
	// ----------------------------------------
	reg  [11:0] next_eff_addr;
	wire [7:0]  f_addr;
	assign f_addr = instr[7:0];

	// Access bank, indexed mode or bank select
	always @* begin
		if (instr[8]) begin
			next_eff_addr = {bank_select_reg, f_addr};
		end else if (ext_set_en && f_addr <= `CAB_IDX_LIMIT) begin
			// Indexed literal offset from the base pointer
			next_eff_addr = idx_base + {4'h0, f_addr};
		end else if (f_addr < `CAB_ACC_SPLIT) begin
			next_eff_addr = {4'h0, f_addr};
		end else begin
			next_eff_addr = {`CAB_SFR_BANK, f_addr};
		end
	end

	// ----------------------------------------
	// ALU
	// ----------------------------------------
	wire [7:0] alu_res;
	wire [4:0] alu_flags;
	wire [7:0] alu_b;
	assign alu_b = (kind == K_ANDL) ? instr[7:0] : operand;

	cab_alu u_alu (
		.op_and   (kind != K_ADDC),
		.opnd_a   (acc),
		.opnd_b   (alu_b),
		.carry_in ((kind == K_ADDC) ? status[`CAB_ST_C] : 1'b0),
		.result   (alu_res),
		.flags    (alu_flags)
	);

	// Branch target: incremented PC plus twice signed offset
	wire [20:0] pc_inc;
	wire [20:0] pc_jump;
	assign pc_inc  = pc + `CAB_PC_STEP;
	assign pc_jump = pc_inc +
		{{12{instr[7]}}, instr[7:0], 1'b0};

	// ----------------------------------------
	// Phase sequencer
	// ----------------------------------------
	// One state per quarter; taken branch adds a four-quarter NOP
	always @(posedge core_clk) begin
		if (rst) begin
			state       <= S_IDLE;
			quarter     <= 2'h0;
			kind        <= K_NONE;
			eff_addr    <= 12'h000;
			operand     <= 8'h00;
			res         <= 8'h00;
			res_flags   <= 5'h00;
			take_branch <= 1'b0;
			exec_busy   <= 1'b0;
		end else begin
			case (state)
			S_IDLE: begin
				// Instruction register write launches execution
				if (wr_go && avs_address == `CAB_OFS_INSTR) begin
					state     <= S_Q1;
					exec_busy <= 1'b1;
				end
			end
			S_Q1: begin
				// Decode
				kind     <= decode_kind(instr);
				eff_addr <= next_eff_addr;
				state    <= S_Q2;
			end
			S_Q2: begin
				// Read operand; carry sampled for branch
				operand     <= mem[eff_addr];
				take_branch <= (kind == K_BRC) &&
					status[`CAB_ST_C];
				state       <= S_Q3;
			end
			S_Q3: begin
				// Process data
				res       <= alu_res;
				res_flags <= alu_flags;
				state     <= S_Q4;
			end
			S_Q4: begin
				// Destination written elsewhere this quarter
				quarter <= 2'h0;
				if (take_branch) begin
					state <= S_NOP;
				end else begin
					state     <= S_IDLE;
					exec_busy <= 1'b0;
				end
			end
			S_NOP: begin
				// Second cycle of a taken branch does nothing
				quarter <= quarter + 2'h1;
				if (quarter == `CAB_QUARTERS) begin
					state     <= S_IDLE;
					exec_busy <= 1'b0;
				end
			end
			default: begin
				state     <= S_IDLE;
				exec_busy <= 1'b0;
			end
			endcase
		end
	end

	// ----------------------------------------
	// Register window
	// ----------------------------------------
	// One mux serves reads and the byte-lane merge of writes
	reg  [31:0] reg_word;       // Current value at avs_address
	wire [31:0] wr_word;        // That value with write lanes merged
	always @* begin
		if (avs_address == `CAB_OFS_CTRL)
			reg_word = {31'h0, ext_set_en};
		else if (avs_address == `CAB_OFS_INSTR)
			reg_word = {16'h0, instr};
		else if (avs_address == `CAB_OFS_ACC)
			reg_word = {24'h0, acc};
		else if (avs_address == `CAB_OFS_STATUS)
			reg_word = {23'h0, exec_busy, 3'h0, status};
		else if (avs_address == `CAB_OFS_BANK_SEL)
			reg_word = {28'h0, bank_select_reg};
		else if (avs_address == `CAB_OFS_PC)
			reg_word = {11'h0, pc};
		else if (avs_address == `CAB_OFS_IDX_BASE)
			reg_word = {20'h0, idx_base};
		else if (avs_address == `CAB_OFS_MADDR)
			reg_word = {20'h0, mem_addr};
		else if (avs_address == `CAB_OFS_MDATA)
			reg_word = {24'h0, mem[mem_addr]};
		else
			// Unmapped offsets read as zero and ignore writes
			reg_word = 32'h00000000;
	end
	assign wr_word = be_merge(reg_word, avs_writedata, avs_byteenable);

	// ----------------------------------------
	// Accumulator, flags and program counter
	// ----------------------------------------
	wire q4_done;
	wire wr_idle;
	assign q4_done = (state == S_Q4);
	assign wr_idle = wr_go && (state == S_IDLE);

	// Execution writes in Q4; software writes only while idle
	always @(posedge core_clk) begin
		if (rst) begin
			acc    <= `CAB_RST_ACC;
			status <= `CAB_RST_STATUS;
			pc     <= `CAB_RST_PC;
		end else if (q4_done) begin
			if (kind == K_ANDL ||
				((kind == K_ADDC || kind == K_ANDF) && !instr[9]))
				acc <= res;
			if (kind == K_ADDC)
				status <= res_flags;
			else if (kind == K_ANDF || kind == K_ANDL) begin
				// Only negative and zero move for AND
				status[`CAB_ST_N] <= res_flags[`CAB_ST_N];
				status[`CAB_ST_Z] <= res_flags[`CAB_ST_Z];
			end
			pc <= take_branch ? pc_jump : pc_inc;
		end else if (wr_idle) begin
			if (avs_address == `CAB_OFS_ACC)
				acc <= wr_word[7:0];
			else if (avs_address == `CAB_OFS_STATUS)
				status <= wr_word[4:0];
			else if (avs_address == `CAB_OFS_PC)
				// Bit 0 forced low: instructions sit on even bytes
				pc <= {wr_word[20:1], 1'b0};
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Held stable while busy so an instruction sees one mapping
	always @(posedge core_clk) begin
		if (rst) begin
			bank_select_reg <= `CAB_RST_BANK_SEL;
			idx_base        <= 12'h000;
			mem_addr        <= 12'h000;
			ext_set_en      <= 1'b0;
			instr           <= 16'h0000;
		end else if (wr_idle) begin
			if (avs_address == `CAB_OFS_CTRL)
				ext_set_en <= wr_word[0];
			else if (avs_address == `CAB_OFS_INSTR)
				instr <= wr_word[15:0];
			else if (avs_address == `CAB_OFS_BANK_SEL)
				bank_select_reg <= wr_word[3:0];
			else if (avs_address == `CAB_OFS_IDX_BASE)
				idx_base <= wr_word[11:0];
			else if (avs_address == `CAB_OFS_MADDR)
				mem_addr <= wr_word[11:0];
		end
	end

	// ----------------------------------------
	// Data memory port
	// ----------------------------------------
	// File destination written in Q4; software port when idle
	always @(posedge core_clk) begin
		if (q4_done && instr[9] &&
			(kind == K_ADDC || kind == K_ANDF))
			mem[eff_addr] <= res;
		else if (wr_idle && avs_address == `CAB_OFS_MDATA &&
			avs_byteenable[0])
			mem[mem_addr] <= avs_writedata[7:0];
	end

	// ----------------------------------------
	// Avalon-MM slave handshake
	// ----------------------------------------
	// Fixed one wait state; read data loaded as waitrequest falls
	always @(posedge core_clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (bus_req) begin
			avs_waitrequest <= 1'b0;
			if (rd_fire)
				avs_readdata <= reg_word;
		end
	end
endmodule // cab_core

// ---- dv/cab_chk.sv ----
// Purpose: bus and busy timing checks for cab_core
// Assumes: one clock, synchronous active-high reset
// Notes:   attached by bind at the foot of this file
`include "cab_defines.vh"
module cab_chk (
	input logic        core_clk,
	input logic        rst,
	input logic [5:0]  avs_address,
	input logic        avs_read,
	input logic        avs_write,
	input logic [31:0] avs_writedata,
	input logic [3:0]  avs_byteenable,
	input logic [31:0] avs_readdata,
	input logic        avs_waitrequest,
	input logic        exec_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------
	// Helpers
	// ------
	// Instruction load completing while idle; a busy load is ignored
	wire        go = avs_write && !avs_waitrequest && !exec_busy
		&& avs_address == `CAB_OFS_INSTR;
	wire [15:0] iw = avs_writedata[15:0]; // Word being loaded
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// ------
	// Assertions
	// ------
	a_wait_single:
		assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low two cycles running");
	a_answer_next:
		assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
		else $error("request not answered after one wait");
	a_busy_start:
		assert property (go |=> exec_busy)
		else $error("busy did not follow instruction load");
	a_busy_cause:
		assert property ($rose(exec_busy) |-> $past(go))
		else $error("busy rose without instruction load");
	a_addc_len:
		assert property (go && iw[15:10] == `CAB_OP_ADDC |=>
			exec_busy [*4] ##1 !exec_busy)
		else $error("add with carry not one instruction cycle");
	a_andf_len:
		assert property (go && iw[15:10] == `CAB_OP_ANDF |=>
			exec_busy [*4] ##1 !exec_busy)
		else $error("file and not one instruction cycle");
	a_andl_len:
		assert property (go && iw[15:8] == `CAB_OP_ANDL |=>
			exec_busy [*4] ##1 !exec_busy)
		else $error("literal and not one instruction cycle");
	a_brc_len:
		assert property (go && iw[15:8] == `CAB_OP_BRC |=>
			exec_busy [*4] ##1
			(!exec_busy or exec_busy [*4] ##1 !exec_busy))
		else $error("branch length neither one nor two cycles");
endmodule // cab_chk

bind cab_core cab_chk i_cab_chk (.core_clk, .rst, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
	.avs_waitrequest, .exec_busy);

// ---- dv/cab_ref_model.sv ----
// Purpose: data memory, registers and program counter of the core,
//          stepped one instruction at a time
// Assumes: the bench preloads the operand byte and the registers
// Notes:   integer arithmetic, masked to register widths
module cab_ref_model;
	timeunit 1ns;
	timeprecision 1ns;
	int mem [4096]; // Data memory bytes
	int r [5];      // Ctrl, bank, index base, accumulator, flags
	int pc;         // Program counter, even, 21 bits
	// Data address of a file operand
	function automatic int ea(int a, int f);
		if (a == 0 && r[0] == 1 && f <= 'h5f)
			return (r[2] + f) & 'hfff;
		if (a == 0)
			return f >= 'h60 ? 'hf00 + f : f;
		return r[1] * 256 + f;
	endfunction
	// Execute one word; returns busy length in core_clk cycles
	function automatic int run(int w);
		int f, d, m, s, a2;
		f = w & 255;
		d = w >> 9 & 1;
		a2 = ea(w >> 8 & 1, f);
		m = mem[a2];
		pc = (pc + 2) & 'h1fffff;
		if (w >> 10 == 'h08) begin
			s = r[3] + m + (r[4] & 1);
			r[4] = s >> 8 | (r[3] % 16 + m % 16 + (r[4] & 1)) >> 4 << 1;
			s &= 255;
			r[4] |= (~(r[3] ^ m) & (r[3] ^ s) & 128) >> 4;
		end else if (w >> 10 == 'h05) begin
			s = r[3] & m;
			r[4] &= 'h0b;
		end else if (w >> 8 == 'h0b) begin
			s = r[3] & f;
			r[4] &= 'h0b;
			d = 0;
		end else begin
			// Flags stay as they are; taken costs a second cycle
			if (w >> 8 == 'he2 && r[4] % 2 == 1) begin
				pc = (pc + 2 * (f ^ 128) - 256) & 'h1fffff;
				return 8;
			end
			return 4;
		end
		r[4] |= (s == 0) << 2 | s >> 7 << 4; // Zero and negative
		if (d == 0)
			r[3] = s;
		else
			mem[a2] = s;
		return 4;
	endfunction
endmodule // cab_ref_model

// ---- dv/cab_core_tb_top.sv ----
// Purpose: self-checking bench for cab_core against cab_ref_model
// Assumes: one wait state per access, busy watched on exec_busy
// Notes:   random instruction words from a fixed seed
`include "cab_defines.vh"
`define CHK(nm, e, g) begin \
	comparisons++; \
	if ((g) !== 32'(e)) begin \
		n_mismatch++; \
		$display("ERROR %s expected %h seen %h", nm, 32'(e), g); \
	end \
end
module cab_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0]  avs_byteenable = 4'hf; // Narrow data rides lane 0
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        exec_busy;
	logic [31:0] rd;                    // Last read data
	int          n_mismatch, comparisons, i, k, w, a, c, e;
	int          ofs [5] = '{0, 'h10, 'h18, 'h08, 'h0c}; // Model order
	int          lim [5] = '{1, 15, 'hfff, 255, 31};     // Field widths
	// 25 MHz core clock
	always #20 core_clk = ~core_clk;
	cab_core i_cab_core (.core_clk, .rst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .exec_busy);
	cab_ref_model i_cab_ref_model ();
	// ------
	// Tasks
	// ------
	// One bus access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] ad, input int d);
		int t;
		@(posedge core_clk);
		avs_address <= ad;
		avs_writedata <= 32'(d);
		avs_write <= wr;
		avs_read <= !wr;
		for (t = 0; t < 20; t++) begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (t == 20) begin
			n_mismatch++;
			results();
		end
	endtask
	// Counts and verdict
	task automatic results();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ------
	// Sequence
	// ------
	initial begin
		k = $urandom(32'h18b67463);
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		// Idle registers read zero, so does an unmapped place
		bus(1, 6'h24, $urandom);
		for (i = 0; i < 10; i++) begin
			if (i != 8) begin
				bus(0, 6'(i * 4), 0);
				`CHK("reset or unmapped", 0, rd)
			end
		end
		// Random words; the first four sit around the access split
		for (i = 0; i < 48; i++) begin
			c = i < 4 ? i % 2 : $urandom % 4;
			w = c < 2 ? $urandom % 1024 : $urandom % 256;
			w |= c == 0 ? 'h2000 : c == 1 ? 'h1400 : c == 2 ? 'h0b00 : 'he200;
			if (i < 4)
				w = w & 'hfe00 | 'h5e + i;
			for (k = 0; k < 5; k++) begin
				e = $urandom % (lim[k] + 1);
				bus(1, 6'(ofs[k]), e);
				bus(0, 6'(ofs[k]), 0);
				`CHK("register", e, rd)
				i_cab_ref_model.r[k] = e;
			end
			a = i_cab_ref_model.ea(w >> 8 & 1, w & 255);
			e = $urandom % 256;
			bus(1, `CAB_OFS_MADDR, a);
			bus(1, `CAB_OFS_MDATA, e);
			i_cab_ref_model.mem[a] = e;
			e = i_cab_ref_model.run(w);
			bus(1, `CAB_OFS_INSTR, w);
			c = 0;
			for (k = 0; k < 20; k++) begin
				@(posedge core_clk);
				if (exec_busy !== 1'b1)
					break;
				c++;
			end
			if (k == 20) begin
				n_mismatch++;
				results();
			end
			`CHK("busy cycles", e, c)
			bus(0, `CAB_OFS_ACC, 0);
			`CHK("acc", i_cab_ref_model.r[3], rd)
			bus(0, `CAB_OFS_STATUS, 0);
			`CHK("flags", i_cab_ref_model.r[4], rd)
			bus(0, `CAB_OFS_PC, 0);
			`CHK("pc", i_cab_ref_model.pc, rd)
			bus(0, `CAB_OFS_MDATA, 0);
			`CHK("file byte", i_cab_ref_model.mem[a], rd)
		end
		results();
	end
endmodule // cab_core_tb_top
